// ---- hdl/swt_pkg.sv ----
// package: constants and types for the service window timer
package swt_pkg;
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned TC_NS             = 1000;
  localparam int unsigned TC_DIV            = (TC_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [16:0] LOWER_CYC         = 17'h00800;
  localparam logic [16:0] UPPER_8K          = 17'h02000;
  localparam logic [16:0] UPPER_16K         = 17'h04000;
  localparam logic [16:0] UPPER_32K         = 17'h08000;
  localparam logic [16:0] UPPER_64K         = 17'h10000;
  localparam logic [4:0]  KEY_VALUE         = 5'h0C;
  localparam int unsigned WIN_MSB           = 7;
  localparam int unsigned WIN_LSB           = 6;
  localparam int unsigned KEY_MSB           = 5;
  localparam int unsigned KEY_LSB           = 1;
  localparam int unsigned CMON_BIT          = 0;
  localparam logic [1:0]  WIN_RESET         = 2'h3;
  localparam logic        CMON_RESET        = 1'b1;
  localparam logic [5:0]  HOLD_CYC          = 6'h18;
  localparam int unsigned CMON_LIMIT_NS     = 10_000_000;
  localparam logic [3:0]  REG_SERVICE       = 4'h0;
  localparam logic [3:0]  REG_STATUS        = 4'h1;
  localparam logic [3:0]  REG_IDLE_CTL      = 4'h2;
  localparam int unsigned IDLE_TICK_BIT     = 12;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } swt_bus_req_t;

  typedef struct packed {
    logic halt;
    logic idle;
    logic rc_osc;
    logic clk_delay_sel;
  } swt_mode_t;
endpackage

// ---- hdl/swt_timer.sv ----
// service window timer with clock monitor and open-drain fault pin
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Contract
// (RULE1) lower bound fixed at 2048 cycles
// (RULE2) top bits pick 8k/16k/32k/64k upper bound
// (RULE3) key field bits 5..1 must be 01100
// (RULE4) bit 0 enables clock monitor
// (RULE5) inactive in reset; longest window, monitor on
// (RULE6) first keyed write configures, then locked
// (RULE7) later writes mismatching bits raise error
// (RULE8) no service before upper bound is error
// (RULE9) software never services twice per lower bound
// (RULE10) configuring write counts as a service
// (RULE11) fault drives low, holds 16-32 after low
// (RULE12) window restarts when pin senses high
// (RULE13) writes ignored while fault output active; only service writes are gated, idle-control tick clears still act
// (RULE14) monitor holds pin low while clock slow
// (RULE15) no flag above 10 kHz, flag below 10 Hz
// (RULE16) key field reads back as zeros
// (RULE17) window detector inhibited in halt, idle
// (RULE18) clock monitor stays active in halt, idle
// (RULE19) halt exit resumes or reloads window
// (RULE20) idle exit does a hardware service
// (RULE21) idle counter unreset; tick flag every 4096
// (RULE22) first service accepted anywhere, even early
// (RULE23) fault pin level sampled through buffer
module swt_timer #(
  parameter int unsigned TC_DIV_P    = swt_pkg::TC_DIV,
  parameter int unsigned CMON_TC_MAX = swt_pkg::CMON_LIMIT_NS / swt_pkg::TC_NS
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire swt_pkg::swt_bus_req_t bus,
  output logic [7:0]                 rdata,
  input  wire swt_pkg::swt_mode_t    mode,
  input  wire logic                  clock_in_pin,
  input  wire logic                  fault_in,
  output logic                       fault_out,
  output logic                       fault_oe_n,
  output logic                       idle_tick_flag
);
  import swt_pkg::*;

  // instruction cycle enable
  logic [15:0] div_reg;
  wire         tc_en = (div_reg == 16'(TC_DIV_P - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_reg <= 16'h0000;
    else div_reg <= tc_en ? 16'h0000 : div_reg + 16'h0001;
  end

  // synchronisers
  logic [1:0] pin_sync_reg;
  logic [1:0] ck_sync_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_reg <= 2'h0;
      ck_sync_reg  <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], fault_in}; // RULE23
      ck_sync_reg  <= {ck_sync_reg[0], clock_in_pin};
    end
  end
  wire pin_high = pin_sync_reg[1];

  // configuration
  logic [1:0] win_reg;
  logic       cmon_reg;
  logic       cfg_done_reg;
  logic       armed_reg;

  function automatic logic [16:0] upper_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: upper_of = UPPER_8K;
      2'h1: upper_of = UPPER_16K;
      2'h2: upper_of = UPPER_32K;
      2'h3: upper_of = UPPER_64K;
    endcase
  endfunction

  logic        active_reg;
  wire         svc_wr   = bus.wr && (bus.addr == REG_SERVICE) && !active_reg; // RULE13
  wire  [4:0]  wr_key   = bus.wdata[KEY_MSB:KEY_LSB];
  wire  [1:0]  wr_win   = bus.wdata[WIN_MSB:WIN_LSB];
  wire         wr_cmon  = bus.wdata[CMON_BIT];
  wire         key_ok   = (wr_key == KEY_VALUE); // RULE3
  wire         cfg_wr   = svc_wr && !cfg_done_reg; // RULE6
  wire         later_ok = key_ok && (wr_win == win_reg) && (wr_cmon == cmon_reg); // RULE7
  wire         later_wr = svc_wr && cfg_done_reg;

  // halt / idle transitions
  logic halt_d_reg;
  logic idle_d_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_d_reg <= 1'b0;
      idle_d_reg <= 1'b0;
    end else begin
      halt_d_reg <= mode.halt;
      idle_d_reg <= mode.idle;
    end
  end
  wire halt_exit   = halt_d_reg && !mode.halt;
  wire idle_exit   = idle_d_reg && !mode.idle;
  wire halt_reload = halt_exit && !(mode.rc_osc && !mode.clk_delay_sel); // RULE19
  wire inhibit     = mode.halt || mode.idle; // RULE17

  // window counter
  logic [16:0] win_cnt_reg;
  logic        first_reg;
  wire         early     = (win_cnt_reg < LOWER_CYC) && !first_reg; // RULE1 RULE22
  wire         svc_good  = cfg_wr ? key_ok : (later_ok && !early);
  wire         svc_bad   = (cfg_wr && !key_ok) || (later_wr && !(later_ok && !early)); // RULE7
  wire         expired   = tc_en && !inhibit && armed_reg &&
                           (win_cnt_reg + 17'h00001 >= upper_of(win_reg)); // RULE2 RULE8
  wire         restart   = (svc_wr && svc_good) || idle_exit || halt_reload; // RULE10 RULE20
  wire         wd_err    = svc_bad || expired;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_reg      <= WIN_RESET; // RULE5
      cmon_reg     <= CMON_RESET;
      cfg_done_reg <= 1'b0;
      first_reg    <= 1'b1;
    end else if (cfg_wr && key_ok) begin
      win_reg      <= wr_win; // RULE2
      cmon_reg     <= wr_cmon; // RULE4
      cfg_done_reg <= 1'b1; // RULE6
      first_reg    <= 1'b0;
    end
  end

  // window counter and arming
  logic restart_pin_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_cnt_reg <= 17'h00000;
      armed_reg   <= 1'b1;
    end else if (restart || restart_pin_reg) begin
      win_cnt_reg <= 17'h00000; // RULE12
      armed_reg   <= 1'b1;
    end else if (wd_err) begin
      armed_reg   <= 1'b0;
    end else if (tc_en && !inhibit && armed_reg) begin
      win_cnt_reg <= win_cnt_reg + 17'h00001;
    end
  end

  // clock monitor: counts instruction cycles without a rising clock_in_pin edge
  logic        ck_prev_reg;
  logic [31:0] gap_reg;
  logic        slow_reg;
  wire         ck_edge = ck_sync_reg[1] & ~ck_prev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_prev_reg <= 1'b0;
      gap_reg     <= 32'h00000000;
      slow_reg    <= 1'b0;
    end else begin
      ck_prev_reg <= ck_sync_reg[1];
      if (ck_edge) begin
        gap_reg  <= 32'h00000000;
        slow_reg <= 1'b0; // RULE14
      end else if (tc_en) begin
        if (gap_reg >= 32'(CMON_TC_MAX)) slow_reg <= 1'b1; // RULE15 RULE18
        else gap_reg <= gap_reg + 32'h00000001;
      end
    end
  end
  wire cmon_err = cmon_reg && slow_reg; // RULE4 RULE18

  // fault output sequencing
  typedef enum logic [1:0] {FS_IDLE, FS_DRIVE, FS_HOLD, FS_WAIT_HIGH} swt_fault_t;
  swt_fault_t  fs_reg;
  swt_fault_t  fs_next;
  logic [5:0]  hold_reg;
  wire         hold_done = tc_en && (hold_reg == HOLD_CYC);
  always_comb begin
    fs_next = fs_reg;
    unique case (fs_reg)
      FS_IDLE:      if (wd_err || cmon_err) fs_next = FS_DRIVE;
      FS_DRIVE:     if (!pin_high && !cmon_err) fs_next = FS_HOLD; // RULE11
      FS_HOLD:      if (cmon_err) fs_next = FS_DRIVE;
                    else if (hold_done) fs_next = FS_WAIT_HIGH; // RULE11 RULE14
      FS_WAIT_HIGH: if (pin_high) fs_next = FS_IDLE; // RULE12
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_reg          <= FS_IDLE; // RULE5
      hold_reg        <= 6'h00;
      active_reg      <= 1'b0;
      restart_pin_reg <= 1'b0;
    end else begin
      fs_reg          <= fs_next;
      hold_reg        <= (fs_reg != FS_HOLD) ? 6'h00 : (tc_en ? hold_reg + 6'h01 : hold_reg);
      active_reg      <= (fs_next != FS_IDLE);
      restart_pin_reg <= (fs_reg == FS_WAIT_HIGH) && pin_high; // RULE12
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) fault_oe_n <= 1'b1;
    else fault_oe_n <= !((fs_next == FS_DRIVE) || (fs_next == FS_HOLD)); // RULE11
  end
  assign fault_out = 1'b0;

  // idle counter: no reset on purpose
  logic [IDLE_TICK_BIT:0] idle_counter = '0;
  logic                   tick_reg;
  always_ff @(posedge clk) begin
    if (tc_en) idle_counter <= idle_counter + 1'b1; // RULE21
  end
  wire tick_toggle = tc_en && (idle_counter[IDLE_TICK_BIT-1:0] == '1);
  wire tick_clr    = bus.wr && (bus.addr == REG_IDLE_CTL) && bus.wdata[0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tick_reg <= 1'b0;
    else if (tick_toggle) tick_reg <= 1'b1; // RULE21
    else if (tick_clr) tick_reg <= 1'b0;
  end
  assign idle_tick_flag = tick_reg;

  // register read
  wire [7:0] rd_mux =
    (bus.addr == REG_SERVICE)  ? {win_reg, 5'h00, cmon_reg} : // RULE16
    (bus.addr == REG_STATUS)   ? {4'h0, slow_reg, armed_reg, active_reg, cfg_done_reg} :
    (bus.addr == REG_IDLE_CTL) ? {7'h00, tick_reg} : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata <= 8'h00;
    else rdata <= bus.rd ? rd_mux : 8'h00;
  end
endmodule

// ---- tb/swt_timer_monitor.sv ----
// checker on the service window timer ports
`timescale 1ns/1ps
module swt_timer_monitor #(
  parameter int unsigned TC_DIV_P    = 50,
  parameter int unsigned CMON_TC_MAX = 10000
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire swt_pkg::swt_bus_req_t bus,
  input wire logic [7:0]            rdata,
  input wire swt_pkg::swt_mode_t    mode,
  input wire logic                  clock_in_pin,
  input wire logic                  fault_in,
  input wire logic                  fault_out,
  input wire logic                  fault_oe_n,
  input wire logic                  idle_tick_flag
);
  import swt_pkg::*;
  logic [15:0] low_cnt_reg;
  logic [15:0] low_cnt_next;
  assign low_cnt_next = fault_in ? 16'h0000 : low_cnt_reg + {15'h0000, low_cnt_reg != 16'hFFFF};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) low_cnt_reg <= 16'h0000;
    else low_cnt_reg <= low_cnt_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_bad_wr;
    bus.wr && bus.addr == REG_SERVICE && fault_oe_n && bus.wdata[5:1] != KEY_VALUE;
  endsequence
  sequence s_hold_release;
    !fault_oe_n ##[30:72] fault_oe_n;
  endsequence
  a_pin_drive_zero: assert property (fault_out == 1'b0)
    else $error("fault drive value not zero");
  a_reset_quiet: assert property ($fell(rst) |-> fault_oe_n)
    else $error("fault pin driven right after reset");
  a_key_reads_zero: assert property (
    $past(bus.rd) && $past(bus.addr) == REG_SERVICE |-> rdata[5:1] == 5'h00)
    else $error("key field read back non zero");
  a_unmapped_zero: assert property (
    $past(bus.rd) && $past(bus.addr) > REG_IDLE_CTL |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bad_key_err: assert property (s_bad_wr |-> ##[1:2] !fault_oe_n)
    else $error("bad key write raised no fault");
  a_hold_bounded: assert property (s_bad_wr |-> ##[1:2] s_hold_release)
    else $error("fault hold time out of range");
  a_hold_minimum: assert property (
    $rose(fault_oe_n) |-> low_cnt_reg >= 16 * TC_DIV_P)
    else $error("fault released too early");
  a_tick_sticky: assert property (
    idle_tick_flag && !(bus.wr && bus.addr == REG_IDLE_CTL && bus.wdata[0]) |=> idle_tick_flag)
    else $error("tick flag dropped without clear");
endmodule
bind swt_timer swt_timer_monitor #(.TC_DIV_P(TC_DIV_P), .CMON_TC_MAX(CMON_TC_MAX)) u_mon (
  .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .mode(mode),
  .clock_in_pin(clock_in_pin), .fault_in(fault_in), .fault_out(fault_out),
  .fault_oe_n(fault_oe_n), .idle_tick_flag(idle_tick_flag));

// ---- tb/swt_pin_pullup.sv ----
// pull-up and sense buffer on the shared fault pin
`timescale 1ns/1ps
module swt_pin_pullup (
  input  wire logic fault_out,
  input  wire logic fault_oe_n,
  output logic      fault_in
);
  assign fault_in = fault_oe_n ? 1'b1 : fault_out;
endmodule

// ---- tb/test_swt_timer.sv ----
// self-checking bench for the service window timer
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module test_swt_timer;
  import swt_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  swt_bus_req_t bus = '0;
  swt_mode_t    mode = '0;
  logic         clock_in_pin = 1'b0;
  logic         cki_run = 1'b1;
  logic [1:0]   cdiv = 2'h0;
  logic [7:0]   rdata;
  logic         fault_in, fault_out, fault_oe_n, idle_tick_flag;
  logic [7:0]   bad_val [5] = '{8'h59, 8'h99, 8'h18, 8'h1B, 8'h1D};
  int           bad_count = 0;
  int           num_checks = 0;
  int           cyc = 0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cdiv <= cdiv + 2'h1;
    if (cki_run && cdiv == 2'h3) clock_in_pin <= ~clock_in_pin;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      bad_count++;
      summarize();
    end
  end
  swt_timer #(.TC_DIV_P(2), .CMON_TC_MAX(20)) dut (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .mode(mode),
    .clock_in_pin(clock_in_pin), .fault_in(fault_in), .fault_out(fault_out),
    .fault_oe_n(fault_oe_n), .idle_tick_flag(idle_tick_flag));
  swt_pin_pullup pin (.fault_out(fault_out), .fault_oe_n(fault_oe_n), .fault_in(fault_in));
  task automatic tc(input int n);
    repeat (2 * n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic svc(input logic [7:0] d, input logic e);
    wr(REG_SERVICE, d);
    tc(1);
    `CHK("fault_oe_n", e, fault_oe_n)
  endtask
  task automatic wrel();
    int i;
    for (i = 0; i < 400 && fault_oe_n !== 1'b1; i++) @(posedge clk);
    `CHK("release", 1'b1, fault_oe_n)
    tc(5);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(REG_SERVICE, 8'hC1);
    svc(8'h19, 1'b1);
    rd(REG_SERVICE, 8'h01);
    tc(2100);
    svc(8'h19, 1'b1);
    tc(100);
    svc(8'h19, 1'b0);
    svc(8'h1B, 1'b0);
    wrel();
    foreach (bad_val[i]) begin
      tc(2100);
      svc(bad_val[i], 1'b0);
      wrel();
    end
    tc(2100);
    svc(8'h19, 1'b1);
    @(posedge clk);
    mode.idle <= 1'b1;
    tc(100);
    @(posedge clk);
    mode.idle <= 1'b0;
    tc(10);
    svc(8'h19, 1'b0);
    wrel();
    tc(2100);
    svc(8'h19, 1'b1);
    @(posedge clk);
    mode.halt <= 1'b1;
    tc(9000);
    `CHK("halt", 1'b1, fault_oe_n)
    @(posedge clk);
    mode.halt <= 1'b0;
    tc(2100);
    svc(8'h19, 1'b1);
    tc(8100);
    `CHK("upper", 1'b1, fault_oe_n)
    tc(100);
    `CHK("upper", 1'b0, fault_oe_n)
    wrel();
    cki_run <= 1'b0;
    tc(30);
    `CHK("cmon", 1'b0, fault_oe_n)
    cki_run <= 1'b1;
    wrel();
    `CHK("tick", 1'b1, idle_tick_flag)
    wr(REG_IDLE_CTL, 8'h01);
    #1;
    `CHK("tick", 1'b0, idle_tick_flag)
    rd(4'hF, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(REG_SERVICE, 8'hC1);
    svc(8'hD8, 1'b1);
    rd(REG_SERVICE, 8'hC0);
    cki_run <= 1'b0;
    tc(60);
    `CHK("cmon_off", 1'b1, fault_oe_n)
    cki_run <= 1'b1;
    tc(2100);
    @(posedge clk);
    mode <= '{halt: 1'b1, idle: 1'b0, rc_osc: 1'b1, clk_delay_sel: 1'b0};
    tc(50);
    @(posedge clk);
    mode.halt <= 1'b0;
    svc(8'hD8, 1'b1);
    summarize();
  end
endmodule
